//--- core/ssf_pkg.sv
// Package: register map, field positions, reset values and flush timing for the status block
package ssf_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_IRQ_MASK = 10'h000;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h001;
  localparam logic [9:0] IDX_LIVE_STATUS = 10'h002;
  localparam logic [9:0] IDX_FIFO_FLUSH_CONTROL = 10'h003;
  localparam logic [9:0] IDX_MONITOR_ENABLE = 10'h006;

  // Field positions shared by live status, change status and mask
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_TX_PLL_LOCK = 1;
  localparam int BIT_RECOVERY_LOCK = 2;
  localparam int BIT_SIGNAL_LOSS = 3;
  localparam int BIT_EXT_OSC_LOCK = 4;
  localparam int BIT_PATTERN_ERROR = 5;
  localparam int BIT_PATTERN_SYNC = 6;
  localparam int STATUS_WIDTH = 7;

  // Flush control fields
  localparam int BIT_MANUAL_FLUSH = 0;
  localparam int BIT_AUTO_FLUSH = 1;

  // Monitor enable fields
  localparam int BIT_PATTERN_GEN_ENABLE = 0;
  localparam int BIT_EXT_OSC_LOCK_ENABLE = 1;

  // Values after reset
  localparam logic [6:0] STATUS_RESET = 7'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Flush drain length, in transmit parallel clock cycles
  localparam int FLUSH_MIN_TICKS = 8;
  localparam int FLUSH_MAX_TICKS = 10;
  localparam logic [3:0] FLUSH_TICKS = 4'((FLUSH_MIN_TICKS + FLUSH_MAX_TICKS) / 2);
  localparam logic [3:0] TICK_COUNT_RESET = 4'h0;

  // Flush sequencer states
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_HOLD = 3'b010,
    FL_DRAIN = 3'b100
  } ssf_flush_state_e;
endpackage

//--- core/ssf_flush_if.sv
// Interface: request and progress signals between register bank and flush sequencer
`timescale 1ns/1ps
interface ssf_flush_if;
  logic manual_req;
  logic auto_req;
  logic tick;
  logic flushing;
  logic done;

  modport ctrl (output manual_req, output auto_req, output tick, input flushing, input done);
  modport seq (input manual_req, input auto_req, input tick, output flushing, output done);
endinterface

//--- core/ssf_flush_timer.sv
// Flush sequencer: holds FIFO flush while requested, then drains for a fixed tick count
`timescale 1ns/1ps
module ssf_flush_timer (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  ssf_flush_if.seq fl
);
  ssf_pkg::ssf_flush_state_e state;
  ssf_pkg::ssf_flush_state_e next_state;
  logic [3:0] ticks;
  logic [3:0] next_ticks;
  logic flushing;
  logic done;

  wire drain_end = (ticks == ssf_pkg::FLUSH_TICKS - 4'h1) && fl.tick;

  // State and tick counter next values
  always_comb begin
    next_state = state;
    next_ticks = ticks;
    case (state)
      ssf_pkg::FL_IDLE: begin
        if (fl.manual_req) begin
          next_state = ssf_pkg::FL_HOLD;
        end else if (fl.auto_req) begin
          next_state = ssf_pkg::FL_DRAIN;
          next_ticks = ssf_pkg::TICK_COUNT_RESET;
        end
      end
      ssf_pkg::FL_HOLD: begin
        // Drain only starts once software lets go of the bit
        if (!fl.manual_req) begin
          next_state = ssf_pkg::FL_DRAIN;
          next_ticks = ssf_pkg::TICK_COUNT_RESET;
        end
      end
      ssf_pkg::FL_DRAIN: begin
        if (fl.manual_req) begin
          next_state = ssf_pkg::FL_HOLD; // Re-assert restarts the flush
        end else if (drain_end) begin
          next_state = ssf_pkg::FL_IDLE;
        end else if (fl.tick) begin
          next_ticks = ticks + 4'h1;
        end
      end
      default: begin
        next_state = ssf_pkg::FL_IDLE;
      end
    endcase
  end

  // Sequencer registers; outputs are flops so the FIFO reset is glitch free
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ssf_pkg::FL_IDLE;
      ticks <= ssf_pkg::TICK_COUNT_RESET;
      flushing <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      ticks <= next_ticks;
      flushing <= (next_state != ssf_pkg::FL_IDLE);
      done <= (state == ssf_pkg::FL_DRAIN) && (next_state == ssf_pkg::FL_IDLE);
    end
  end

  assign fl.flushing = flushing;
  assign fl.done = done;
endmodule

//--- core/ssf_top.sv
// Top: live status and FIFO flush control registers on an APB slave, with change interrupts
//
// Function
// - Bit 6 shows pattern checker lock while the pattern generator is enabled.
// - Bit 5 shows a present pattern validation error; meaningful with generator enabled.
// - Bit 4 shows external oscillator lock; meaningful with its lock enable set.
// - Bit 3 shows loss of signal on the receive input.
// - Bit 2 shows clock and data recovery lock.
// - Bit 1 shows transmit clock multiplier lock.
// - Bit 0 shows transmit FIFO overflow.
// - With automatic flush set, an overflow flushes the FIFO by itself.
// - With automatic flush clear, overflow causes no flush; software must flush.
// - After manual bit falls, the flush completes in 8 to 10 transmit cycles.
// - Each overflow change sets a read-cleared status bit; interrupt only when enabled.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module ssf_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pattern_checker_in_sync_i,
  input wire logic pattern_check_error_i,
  input wire logic ext_osc_lock_flag_i,
  input wire logic signal_loss_flag_i,
  input wire logic recovery_lock_flag_i,
  input wire logic tx_pll_lock_flag_i,
  input wire logic overflow_flag_i,
  input wire logic tx_parallel_clock_out_i,
  output logic fifo_flush_o,
  output logic flush_done_o,
  output logic pattern_gen_enable_o,
  output logic ext_osc_lock_enable_o,
  output logic irq_o
);
  ssf_flush_if fl ();

  logic [6:0] live_status;
  logic [6:0] overflow_change_status;
  logic [6:0] overflow_irq_mask;
  logic [1:0] fifo_flush_control;
  logic [1:0] monitor_enable;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] next_prdata;

  // Bus decode: a transfer completes on the edge where our registered ready is seen
  wire [9:0] reg_idx = paddr_i[11:2];
  wire access = psel_i && penable_i;
  wire complete = access && pready;
  wire wr_done = complete && pwrite_i;
  wire rd_done = complete && !pwrite_i;
  wire hit_mask = (reg_idx == ssf_pkg::IDX_IRQ_MASK);
  wire hit_chg = (reg_idx == ssf_pkg::IDX_IRQ_STATUS);
  wire hit_live = (reg_idx == ssf_pkg::IDX_LIVE_STATUS);
  wire hit_ctrl = (reg_idx == ssf_pkg::IDX_FIFO_FLUSH_CONTROL);
  wire hit_mon = (reg_idx == ssf_pkg::IDX_MONITOR_ENABLE);
  wire mapped = hit_mask || hit_chg || hit_live || hit_ctrl || hit_mon;

  // Qualifiers: pattern bits only mean something with the generator running
  wire pat_en = monitor_enable[ssf_pkg::BIT_PATTERN_GEN_ENABLE];
  wire osc_en = monitor_enable[ssf_pkg::BIT_EXT_OSC_LOCK_ENABLE];
  wire [6:0] status_valid = {pat_en, pat_en, osc_en, 4'hf};

  // Live sources in register bit order
  wire [6:0] status_src = {
    pattern_checker_in_sync_i,
    pattern_check_error_i,
    ext_osc_lock_flag_i,
    signal_loss_flag_i,
    recovery_lock_flag_i,
    tx_pll_lock_flag_i,
    overflow_flag_i
  };
  wire [6:0] next_live = status_src & status_valid;
  wire [6:0] status_change = next_live ^ live_status;

  // Clear terms: read of the change register clears, so does writing ones
  wire chg_read_clear = rd_done && hit_chg;
  wire [6:0] chg_write_clear = (wr_done && hit_chg) ? pwdata_i[6:0] : 7'h00;

  // Automatic flush fires on the rising edge of overflow only when enabled
  wire overflow_rise = next_live[ssf_pkg::BIT_OVERFLOW] && !live_status[ssf_pkg::BIT_OVERFLOW];
  wire auto_on = fifo_flush_control[ssf_pkg::BIT_AUTO_FLUSH];

  assign fl.auto_req = overflow_rise && auto_on;
  assign fl.manual_req = fifo_flush_control[ssf_pkg::BIT_MANUAL_FLUSH];
  assign fl.tick = tx_parallel_clock_out_i;

  // Read data mux; unused bit positions read as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_mask) begin
      next_prdata[6:0] = overflow_irq_mask;
    end else if (hit_chg) begin
      next_prdata[6:0] = overflow_change_status;
    end else if (hit_live) begin
      next_prdata[6:0] = live_status;
    end else if (hit_ctrl) begin
      next_prdata[1:0] = fifo_flush_control;
    end else if (hit_mon) begin
      next_prdata[1:0] = monitor_enable;
    end
  end

  // APB slave: one wait state so data and ready both leave flops
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= ssf_pkg::RDATA_RESET;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata <= (access && !pready && !pwrite_i) ? next_prdata : ssf_pkg::RDATA_RESET;
    end
  end

  // Live status register: sampled each cycle, never latched, bus writes have no path here
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_status <= ssf_pkg::STATUS_RESET;
    end else begin
      live_status <= next_live;
    end
  end

  // Software written control registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_flush_control <= ssf_pkg::CONTROL_RESET;
      monitor_enable <= ssf_pkg::CONTROL_RESET;
      overflow_irq_mask <= ssf_pkg::STATUS_RESET;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        fifo_flush_control <= pwdata_i[1:0];
      end
      if (hit_mon) begin
        monitor_enable <= pwdata_i[1:0];
      end
      if (hit_mask) begin
        overflow_irq_mask <= pwdata_i[6:0];
      end
    end
  end

  // Sticky change bits, one per status source; a change in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < ssf_pkg::STATUS_WIDTH; gi = gi + 1) begin : g_chg
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          overflow_change_status[gi] <= 1'b0;
        end else if (status_change[gi]) begin
          overflow_change_status[gi] <= 1'b1;
        end else if (chg_read_clear || chg_write_clear[gi]) begin
          overflow_change_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt output: level, high while any enabled change bit is set
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= |(overflow_change_status & overflow_irq_mask);
    end
  end

  // Flush sequencer; counts transmit clock ticks, not system cycles
  ssf_flush_timer u_flush (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .fl(fl.seq)
  );

  assign prdata_o = prdata;
  assign pready_o = pready;
  assign pslverr_o = pslverr;
  assign irq_o = irq;
  assign fifo_flush_o = fl.flushing;
  assign flush_done_o = fl.done;
  assign pattern_gen_enable_o = pat_en;
  assign ext_osc_lock_enable_o = osc_en;
endmodule

//--- testbench/ssf_chk.sv
// Checker: bus timing, live status read-back and flush completion of the status block
`timescale 1ns/1ps
module ssf_chk (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic signal_loss_flag_i,
  input wire logic recovery_lock_flag_i,
  input wire logic tx_pll_lock_flag_i,
  input wire logic overflow_flag_i,
  input wire logic fifo_flush_o,
  input wire logic flush_done_o,
  input wire logic pattern_gen_enable_o,
  input wire logic ext_osc_lock_enable_o,
  input wire logic irq_o
);
  // Completed read of the live status word
  wire rd_live = psel_i && penable_i && !pwrite_i && pready_o && paddr_i[11:2] == ssf_pkg::IDX_LIVE_STATUS;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Sources must be held steady around a read, else the two-edge lag is ambiguous
  chk_wait_state: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o) else $error("bad wait state");
  chk_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside transfer");
  chk_live_bits: assert property (rd_live |-> prdata_o[3:0] == {
    $past(signal_loss_flag_i, 2), $past(recovery_lock_flag_i, 2), $past(tx_pll_lock_flag_i, 2),
    $past(overflow_flag_i, 2)}) else $error("live bits wrong");
  chk_gate_pattern: assert property (
    rd_live && !$past(pattern_gen_enable_o, 2) |-> prdata_o[6:5] == 2'h0) else $error("pattern bits not gated");
  chk_gate_osc: assert property (
    rd_live && !$past(ext_osc_lock_enable_o, 2) |-> !prdata_o[4]) else $error("osc bit not gated");
  chk_live_unused: assert property (rd_live |-> prdata_o[31:7] == 25'h0) else $error("unused bits set");
  chk_done_pulse: assert property (
    flush_done_o |-> $fell(fifo_flush_o) ##1 !flush_done_o) else $error("bad flush done");
  cover property (flush_done_o);
  cover property (pslverr_o);
  cover property ($rose(irq_o));
endmodule
bind ssf_top ssf_chk u_chk (.*);

//--- testbench/tb_status_and_fifo_flush_control.sv
// Testbench: APB register access, live status, change interrupt and FIFO flush timing
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module tb_status_and_fifo_flush_control;
  logic sys_clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, tx_parallel_clock_out_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, fifo_flush_o, flush_done_o, pattern_gen_enable_o, ext_osc_lock_enable_o, irq_o, er;
  logic pattern_checker_in_sync_i, pattern_check_error_i, ext_osc_lock_flag_i, signal_loss_flag_i;
  logic recovery_lock_flag_i, tx_pll_lock_flag_i, overflow_flag_i;
  logic [6:0] src = 7'h00;
  int num_errors = 0, tests_run = 0, tcnt = 0, n;
  assign {pattern_checker_in_sync_i, pattern_check_error_i, ext_osc_lock_flag_i, signal_loss_flag_i,
    recovery_lock_flag_i, tx_pll_lock_flag_i, overflow_flag_i} = src;
  ssf_top uut (.*);
  initial forever #20 sys_clk_i = ~sys_clk_i;
  // Transmit clock stand-in: one tick every fourth system cycle
  always @(posedge sys_clk_i) begin
    tcnt <= (tcnt + 1) % 4;
    tx_parallel_clock_out_i <= (tcnt == 3);
  end
  // One APB transfer; waits for ready under a bound
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int g;
    @(posedge sys_clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1;
    g = 0;
    do begin
      @(posedge sys_clk_i);
      g++;
    end while (pready_o !== 1'b1 && g < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (g >= 20) `CHK(1'b0, 1'b1)
  endtask
  task set_src(input logic [6:0] v);
    @(posedge sys_clk_i);
    src <= v;
  endtask
  task settle(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask
  // Counts transmit ticks until the flush reports done
  task drain;
    int g;
    n = 0;
    g = 0;
    do begin
      @(posedge sys_clk_i);
      n += tx_parallel_clock_out_i;
      g++;
    end while (flush_done_o !== 1'b1 && g < 200);
    // A drain that never ends is a failure of its own
    if (g >= 200) `CHK(1'b0, 1'b1)
  endtask
  task t_reset;
    apb(0, ssf_pkg::IDX_LIVE_STATUS, 0); `CHK(rd, 32'h0)
    apb(0, ssf_pkg::IDX_FIFO_FLUSH_CONTROL, 0); `CHK(rd, 32'h0)
    `CHK(fifo_flush_o, 1'b0)
  endtask
  task t_live;
    apb(1, ssf_pkg::IDX_MONITOR_ENABLE, 32'h3);
    settle(1);
    `CHK(pattern_gen_enable_o, 1'b1)
    `CHK(ext_osc_lock_enable_o, 1'b1)
    for (int i = 0; i < 7; i++) begin
      set_src(7'(1 << i));
      settle(3);
      apb(0, ssf_pkg::IDX_LIVE_STATUS, 0); `CHK(rd, 32'(1 << i))
    end
    apb(1, ssf_pkg::IDX_LIVE_STATUS, 32'h7f);
    apb(0, ssf_pkg::IDX_LIVE_STATUS, 0); `CHK(rd, 32'h40)
    apb(1, ssf_pkg::IDX_MONITOR_ENABLE, 32'h0);
    settle(1);
    `CHK(pattern_gen_enable_o, 1'b0)
    `CHK(ext_osc_lock_enable_o, 1'b0)
    set_src(7'h7f);
    settle(3);
    apb(0, ssf_pkg::IDX_LIVE_STATUS, 0); `CHK(rd, 32'h0f)
    `CHK(irq_o, 1'b0)
    set_src(7'h00);
    settle(3);
    apb(0, ssf_pkg::IDX_IRQ_STATUS, 0);
  endtask
  // Overflow with auto flush off: interrupt only, no flush
  task t_irq;
    apb(1, ssf_pkg::IDX_IRQ_MASK, 32'h1);
    set_src(7'h01);
    settle(4);
    `CHK(irq_o, 1'b1)
    `CHK(fifo_flush_o, 1'b0)
    apb(0, ssf_pkg::IDX_IRQ_STATUS, 0); `CHK(rd[0], 1'b1)
    settle(2);
    `CHK(irq_o, 1'b0)
    apb(1, ssf_pkg::IDX_IRQ_MASK, 32'h0);
    set_src(7'h00);
    settle(4);
    `CHK(irq_o, 1'b0)
    apb(0, ssf_pkg::IDX_IRQ_STATUS, 0); `CHK(rd[0], 1'b1)
  endtask
  task t_auto;
    apb(1, ssf_pkg::IDX_FIFO_FLUSH_CONTROL, 32'h2);
    set_src(7'h01);
    drain;
    `CHK(n >= 8 && n <= 10, 1'b1)
    set_src(7'h00);
  endtask
  task t_manual;
    apb(1, ssf_pkg::IDX_FIFO_FLUSH_CONTROL, 32'h1);
    settle(1);
    `CHK(fifo_flush_o, 1'b1)
    repeat (12) @(posedge sys_clk_i);
    apb(0, ssf_pkg::IDX_FIFO_FLUSH_CONTROL, 0); `CHK(rd, 32'h1)
    apb(1, ssf_pkg::IDX_FIFO_FLUSH_CONTROL, 32'h0);
    drain;
    `CHK(n >= 8 && n <= 10, 1'b1)
  endtask
  task t_unmapped;
    apb(0, 10'h005, 0); `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
  endtask
  task print_verdict;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 0;
    t_reset; t_live; t_irq; t_auto; t_manual; t_unmapped;
    print_verdict;
  end
  // Watchdog: far beyond the 24 transfers above
  initial begin
    #400000;
    num_errors++;
    print_verdict;
  end
endmodule
